// >>> rtl/rafc_top.sv
/*
 * Receive automatic flow control: configuration register, FIFO threshold
 * watch, pause requests and half-duplex back pressure.
 * Assumes the MAC supplies FIFO occupancy, frame class and duplex state in
 * the same clock domain, and transmits pause frames on request.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rafc_params.svh"

module rafc_top (
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 ce,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    output logic [31:0]               reg_rdata,
    input  wire logic [13:0]          fifo_used_bytes,
    input  wire rafc_pkg::rafc_frame_t rx_frame,
    input  wire logic                 full_duplex,
    input  wire logic                 speed_10,
    input  wire logic                 tx_enabled,
    input  wire logic                 pause_ack,
    output logic                      pause_req,
    output logic                      pause_zero,
    output logic                      back_pressure
);
    // ****************************************************************
    // Configuration register
    // ****************************************************************
    rafc_pkg::rafc_cfg_t cfg_reg;
    rafc_pkg::rafc_state_t state_reg;
    rafc_pkg::rafc_state_t state_next;
    logic        cfg_sel;
    logic [15:0] hi_bytes;
    logic [15:0] lo_bytes;
    logic [15:0] used16;
    logic        above_hi;
    logic        below_lo;
    logic        enabled;
    logic        frame_hit;
    logic        jam_start;
    logic        jam_busy;
    logic        fire_pause;
    logic        fire_zero;
    logic        pause_req_next;
    logic        pause_zero_next;

    assign cfg_sel = (reg_addr == `RAFC_CFG_OFFSET);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cfg_reg <= rafc_pkg::rafc_cfg_t'(`RAFC_CFG_RESET);
        end else if (ce && reg_wr && cfg_sel) begin
            cfg_reg.high_thr <= reg_wdata[`RAFC_HI_MSB:`RAFC_HI_LSB];
            cfg_reg.low_thr  <= reg_wdata[`RAFC_LO_MSB:`RAFC_LO_LSB];
            cfg_reg.dur_code <= reg_wdata[`RAFC_DUR_MSB:`RAFC_DUR_LSB];
            cfg_reg.sel_mult <= reg_wdata[`RAFC_SEL_MULT];
            cfg_reg.sel_brd  <= reg_wdata[`RAFC_SEL_BRD];
            cfg_reg.sel_addr <= reg_wdata[`RAFC_SEL_ADDR];
            cfg_reg.sel_any  <= reg_wdata[`RAFC_SEL_ANY];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (ce && reg_rd) begin
            reg_rdata <= cfg_sel ? {8'h00, cfg_reg} : 32'h0000_0000;
        end
    end

    // ****************************************************************
    // Threshold compare and frame selection
    // ****************************************************************
    assign used16   = {2'b00, fifo_used_bytes};
    assign hi_bytes = {8'h00, cfg_reg.high_thr} << `RAFC_UNIT_SHIFT;
    assign lo_bytes = {8'h00, cfg_reg.low_thr} << `RAFC_UNIT_SHIFT;
    assign above_hi = (used16 >= hi_bytes);
    assign below_lo = (used16 < lo_bytes);
    assign enabled  = cfg_reg.sel_any | cfg_reg.sel_mult |
                      cfg_reg.sel_brd | cfg_reg.sel_addr;

    assign frame_hit = rx_frame.sof &&
        (cfg_reg.sel_any ||
         (cfg_reg.sel_mult && rx_frame.is_mult) ||
         (cfg_reg.sel_brd  && rx_frame.is_brd) ||
         (cfg_reg.sel_addr && rx_frame.is_addr));

    assign jam_start = !full_duplex && tx_enabled && above_hi &&
                       frame_hit && state_reg != rafc_pkg::RAFC_JAMMING;

    // Full duplex pause needs the any-frame select
    assign fire_pause = full_duplex && tx_enabled && cfg_reg.sel_any &&
                        above_hi && state_reg == rafc_pkg::RAFC_IDLE &&
                        !pause_req;
    assign fire_zero  = full_duplex && tx_enabled && enabled && below_lo &&
                        state_reg == rafc_pkg::RAFC_PAUSED &&
                        !pause_req;

    // ****************************************************************
    // Flow state
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            rafc_pkg::RAFC_IDLE: begin
                if (fire_pause) begin
                    state_next = rafc_pkg::RAFC_PAUSED;
                end else if (jam_start) begin
                    state_next = rafc_pkg::RAFC_JAMMING;
                end
            end
            rafc_pkg::RAFC_PAUSED: begin
                if (fire_zero || !full_duplex || !enabled) begin
                    state_next = rafc_pkg::RAFC_IDLE;
                end
            end
            rafc_pkg::RAFC_JAMMING: begin
                if (!jam_busy && !jam_start) begin
                    state_next = rafc_pkg::RAFC_IDLE;
                end
            end
            default: begin
                state_next = rafc_pkg::RAFC_IDLE;
            end
        endcase
    end

    // Request held until the MAC accepts it
    assign pause_req_next  = (fire_pause || fire_zero) ? 1'b1 :
                             (pause_ack ? 1'b0 : pause_req);
    assign pause_zero_next = fire_zero ? 1'b1 :
                             (fire_pause ? 1'b0 : pause_zero);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg     <= rafc_pkg::RAFC_IDLE;
            pause_req     <= 1'b0;
            pause_zero    <= 1'b0;
            back_pressure <= 1'b0;
        end else if (ce) begin
            state_reg     <= state_next;
            pause_req     <= pause_req_next;
            pause_zero    <= pause_zero_next;
            back_pressure <= (jam_busy || jam_start) && tx_enabled &&
                             !full_duplex;
        end
    end

    rafc_jam_timer u_jam_timer (
        .clk      (clk),
        .rstn     (rstn),
        .ce       (ce),
        .start    (jam_start),
        .code     (cfg_reg.dur_code),
        .speed_10 (speed_10),
        .busy     (jam_busy)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Remembers that a full pause was accepted, for the zero pause check
    logic full_sent_reg;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            full_sent_reg <= 1'b0;
        end else if (ce) begin
            if (pause_ack && pause_req && !pause_zero) begin
                full_sent_reg <= 1'b1;
            end else if (fire_zero) begin
                full_sent_reg <= 1'b0;
            end
        end
    end

    sequence hi_reached_s;
        ce && fire_pause;
    endsequence

    sequence pause_raised_s;
        pause_req && !pause_zero;
    endsequence

    one_pause_a: assert property (@(posedge clk) disable iff (!rstn)
        hi_reached_s |=> pause_raised_s)
        else $error("pause not requested at high threshold");
    zero_gate_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && fire_zero |-> full_sent_reg)
        else $error("zero pause without prior pause");
    zero_pause_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && fire_zero |=> pause_req && pause_zero)
        else $error("zero pause not requested");
    tx_off_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && !tx_enabled |=> !back_pressure)
        else $error("back pressure with transmitter off");
    fd_no_jam_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && full_duplex |=> !back_pressure)
        else $error("back pressure in full duplex");
    jam_start_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && jam_start |=> back_pressure)
        else $error("matching frame not jammed");
    sel_any_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && cfg_reg.sel_any && rx_frame.sof && !full_duplex &&
        tx_enabled && above_hi && state_reg == rafc_pkg::RAFC_IDLE
        |=> back_pressure)
        else $error("any-frame select not honoured");
    hi_compare_a: assert property (@(posedge clk) disable iff (!rstn)
        above_hi == (fifo_used_bytes >= 14'(cfg_reg.high_thr * 64)))
        else $error("threshold compare wrong");
    reset_cfg_a: assert property (@(posedge clk)
        !rstn |=> cfg_reg == rafc_pkg::rafc_cfg_t'(`RAFC_CFG_RESET))
        else $error("configuration not cleared by reset");
endmodule // rafc_top

`default_nettype wire

// >>> rtl/rafc_params.svh
/*
 * Constants for the receive automatic flow control block.
 * Assumes a 40 MHz MAC clock and byte counts for FIFO occupancy.
 */
`ifndef RAFC_PARAMS_SVH
`define RAFC_PARAMS_SVH

`define RAFC_CFG_OFFSET      8'hac
`define RAFC_HI_MSB          23
`define RAFC_HI_LSB          16
`define RAFC_LO_MSB          15
`define RAFC_LO_LSB          8
`define RAFC_DUR_MSB         7
`define RAFC_DUR_LSB         4
`define RAFC_SEL_MULT        3
`define RAFC_SEL_BRD         2
`define RAFC_SEL_ADDR        1
`define RAFC_SEL_ANY         0
`define RAFC_CFG_RESET       24'h000000
`define RAFC_UNIT_SHIFT      6
`define RAFC_CLK_MHZ         40
`define RAFC_DUR_BASE_NS     5000
`define RAFC_DUR_SLOW_NS     2200
`define RAFC_DUR_C1_NS       10000
`define RAFC_DUR_C2_NS       15000
`define RAFC_DUR_C3_NS       25000
`define RAFC_DUR_STEP_NS     50000
`define RAFC_DUR_STEP_OFS    3
`define RAFC_DUR_CYC(ns)     (((ns) * `RAFC_CLK_MHZ) / 1000)

`endif

// >>> rtl/rafc_pkg.sv
/*
 * Types for the receive automatic flow control block.
 * Assumes rafc_params.svh is compiled alongside.
 */
`default_nettype none
package rafc_pkg;
    typedef struct packed {
        logic [7:0] high_thr;
        logic [7:0] low_thr;
        logic [3:0] dur_code;
        logic       sel_mult;
        logic       sel_brd;
        logic       sel_addr;
        logic       sel_any;
    } rafc_cfg_t;

    typedef struct packed {
        logic sof;
        logic is_mult;
        logic is_brd;
        logic is_addr;
    } rafc_frame_t;

    typedef enum logic [1:0] {
        RAFC_IDLE,
        RAFC_PAUSED,
        RAFC_JAMMING
    } rafc_state_t;
endpackage
`default_nettype wire

// >>> rtl/rafc_jam_timer.sv
/*
 * Back pressure duration timer: loads a cycle count from a 4-bit code and
 * counts down. Assumes a 40 MHz clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rafc_params.svh"

module rafc_jam_timer (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       ce,
    input  wire logic       start,
    input  wire logic [3:0] code,
    input  wire logic       speed_10,
    output logic            busy
);
    logic [15:0] cnt_reg;
    logic [15:0] load_val;
    logic [31:0] dur_ns;

    // Codes 0 to 3 are 5, 10, 15 and 25 us, then 50 us per code step;
    // 10 Mb/s adds 2.2 us
    assign dur_ns = ((code == 4'h0) ? 32'(`RAFC_DUR_BASE_NS) :
                     (code == 4'h1) ? 32'(`RAFC_DUR_C1_NS) :
                     (code == 4'h2) ? 32'(`RAFC_DUR_C2_NS) :
                     (code == 4'h3) ? 32'(`RAFC_DUR_C3_NS) :
                     32'(`RAFC_DUR_STEP_NS) *
                     ({28'h0, code} - 32'(`RAFC_DUR_STEP_OFS)))
                    + (speed_10 ? 32'(`RAFC_DUR_SLOW_NS) : 32'h0);
    assign load_val = 16'(`RAFC_DUR_CYC(dur_ns));
    assign busy = (cnt_reg != 16'h0000);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt_reg <= 16'h0000;
        end else if (ce) begin
            if (start) begin
                // The start cycle is the first jam cycle
                cnt_reg <= load_val - 16'h0001;
            end else if (busy) begin
                cnt_reg <= cnt_reg - 16'h0001;
            end
        end
    end

    jam_length_a: assert property (@(posedge clk) disable iff (!rstn)
        ce && start |=> cnt_reg == $past(load_val) - 16'h0001)
        else $error("jam timer not loaded");
endmodule // rafc_jam_timer

`default_nettype wire

// >>> dv/rafc_link_partner.sv
/* Link partner side model: accepts each pause request after ack_delay + 1
   cycles and counts accepted pauses. Assumes pause_req holds until ack. */
`timescale 1ns/10ps
`default_nettype none
module rafc_link_partner (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       pause_req,
    input  wire logic       pause_zero,
    input  wire logic [3:0] ack_delay,
    output logic            pause_ack,
    output int              n_pause,
    output int              n_zero
);
    // ****
    // Acceptance
    // ****
    logic [3:0] cnt;
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt <= 4'h0;
            pause_ack <= 1'b0;
            n_pause <= 0;
            n_zero <= 0;
        end else begin
            pause_ack <= 1'b0;
            if (pause_req && !pause_ack) begin
                cnt <= cnt + 4'h1;
                if (cnt == ack_delay) begin
                    cnt <= 4'h0;
                    pause_ack <= 1'b1;
                    if (pause_zero) n_zero <= n_zero + 1;
                    else n_pause <= n_pause + 1;
                end
            end
        end
    end
endmodule // rafc_link_partner
`default_nettype wire

// >>> dv/test_rx_auto_flow_control.sv
/* Testbench for the receive flow control block.
   Assumes the design files and the link partner model are compiled. */
`timescale 1ns/10ps
`default_nettype none
module test_rx_auto_flow_control;
    logic                  clk, rstn, reg_wr, reg_rd, fd, spd, tx, ce;
    logic                  ack, req, zero, bp;
    logic [7:0]            addr;
    logic [31:0]           wdata, rdata;
    logic [13:0]           fifo;
    logic [3:0]            dly;
    rafc_pkg::rafc_frame_t frm;
    int                    n_pause, n_zero, n_mismatch, check_count;

    rafc_top uut (.clk(clk), .rstn(rstn), .ce(ce), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata),
        .reg_rdata(rdata), .fifo_used_bytes(fifo), .rx_frame(frm),
        .full_duplex(fd), .speed_10(spd), .tx_enabled(tx),
        .pause_ack(ack), .pause_req(req), .pause_zero(zero),
        .back_pressure(bp));
    rafc_link_partner partner (.clk(clk), .rstn(rstn), .pause_req(req),
        .pause_zero(zero), .ack_delay(dly), .pause_ack(ack),
        .n_pause(n_pause), .n_zero(n_zero));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ****
    // Shared tasks
    // ****
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) #1;
        reg_wr = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk) #1;
        reg_wr = 1'b0;
    endtask
    task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk) #1;
        reg_rd = 1'b1;
        addr = a;
        @(posedge clk) #1;
        reg_rd = 1'b0;
        check(rdata, exp);
    endtask
    task automatic wait_req(input logic want);
        for (int i = 0; i < 20 && req !== want; i++) @(posedge clk) #1;
        if (req !== want) begin
            n_mismatch++;
            end_sim();
        end
    endtask

    // ****
    // Scenarios
    // ****
    task automatic test_regs();
        reg_check(8'hac, 32'h0);
        reg_check(8'ha8, 32'h0);
        reg_write(8'hac, 32'hff02_01f5);
        reg_check(8'hac, 32'h0002_01f5);
    endtask
    task automatic test_pause();
        fd = 1'b1;
        dly = 4'h2;
        reg_write(8'hac, 32'h0002_0101);
        cyc(5);
        check(req, 1'b0);
        fifo = 14'd127;
        cyc(4);
        check(req, 1'b0);
        fifo = 14'd128;
        wait_req(1'b1);
        check(zero, 1'b0);
        wait_req(1'b0);
        cyc(8);
        check(n_pause, 1);
        fifo = 14'd64;
        cyc(4);
        check(req, 1'b0);
        dly = 4'h0;
        fifo = 14'd63;
        wait_req(1'b1);
        check(zero, 1'b1);
        wait_req(1'b0);
        check(n_zero, 1);
        tx = 1'b0;
        fifo = 14'd200;
        cyc(10);
        check(req, 1'b0);
        fifo = 14'h0;
        cyc(2);
        tx = 1'b1;
    endtask
    task automatic test_bp(input logic [3:0] dur, sel, input logic [2:0] cls,
        input logic s10, fdv, txv, input logic [13:0] f, input int exp);
        int n;
        reg_write(8'hac, {16'h0002, 8'h01, dur, sel});
        fd = fdv;
        tx = txv;
        spd = s10;
        fifo = f;
        @(posedge clk) #1;
        frm = {1'b1, cls};
        @(posedge clk) #1;
        frm = 4'h0;
        n = 0;
        for (int i = 0; i < 3 && bp !== 1'b1; i++) @(posedge clk) #1;
        while (bp === 1'b1 && n < 30000) begin
            @(posedge clk) #1;
            n++;
        end
        check(n, exp);
        if (n >= 30000) begin
            n_mismatch++;
            end_sim();
        end
        fifo = 14'h0;
        tx = 1'b1;
        fd = 1'b0;
        cyc(2);
    endtask
    task automatic test_freeze();
        ce = 1'b0;
        reg_write(8'hac, 32'h0000_00ff);
        ce = 1'b1;
        reg_check(8'hac, 32'h0002_01f2);
    endtask
    task automatic test_reset();
        rstn = 1'b0;
        cyc(1);
        rstn = 1'b1;
        reg_check(8'hac, 32'h0);
    endtask

    initial begin
        {rstn, reg_wr, reg_rd, fd, spd, tx} = 6'b000001;
        {addr, wdata, fifo, dly, frm} = '0;
        ce = 1'b1;
        n_mismatch = 0;
        check_count = 0;
        cyc(5);
        rstn = 1'b1;
        test_regs();
        test_pause();
        test_bp(4'h0, 4'h8, 3'b100, 0, 0, 1, 14'd128, 200);
        test_bp(4'h0, 4'h8, 3'b010, 0, 0, 1, 14'd128, 0);
        test_bp(4'h0, 4'h4, 3'b010, 0, 0, 1, 14'd128, 200);
        test_bp(4'h0, 4'h2, 3'b001, 0, 0, 1, 14'd128, 200);
        test_bp(4'h0, 4'h9, 3'b010, 1, 0, 1, 14'd128, 288);
        test_bp(4'h0, 4'h1, 3'b000, 0, 0, 1, 14'd127, 0);
        test_bp(4'h0, 4'h8, 3'b100, 0, 1, 1, 14'd128, 0);
        test_bp(4'h0, 4'h1, 3'b000, 0, 0, 0, 14'd128, 0);
        test_bp(4'h1, 4'h2, 3'b001, 0, 0, 1, 14'd128, 400);
        test_bp(4'h2, 4'h2, 3'b001, 0, 0, 1, 14'd128, 600);
        test_bp(4'h3, 4'h2, 3'b001, 1, 0, 1, 14'd128, 1088);
        test_bp(4'h4, 4'h2, 3'b001, 0, 0, 1, 14'd128, 2000);
        test_bp(4'hf, 4'h2, 3'b001, 0, 0, 1, 14'd128, 24000);
        test_freeze();
        test_reset();
        end_sim();
    end
endmodule // test_rx_auto_flow_control
`default_nettype wire
